/* File: logic/slp_pkg.sv */
// Constants, register map and carrier types of the sixteen-channel lamp PWM block.
package slp_pkg;

    localparam int unsigned SLP_CH_NUM = 16;
    localparam int unsigned SLP_CNT_W = 12;
    localparam int unsigned SLP_SET_W = 13;
    localparam int unsigned SLP_FULL_BIT = 12;

    localparam int unsigned SLP_SYS_HZ = 100_000_000;
    localparam int unsigned SLP_OSC_HZ = 25_000_000;
    localparam int unsigned SLP_OSC_DIV = SLP_SYS_HZ / SLP_OSC_HZ;

    localparam logic [7:0] SLP_OFS_MODE = 8'h00;
    localparam logic [7:0] SLP_OFS_PRESCALE = 8'h01;
    localparam logic [7:0] SLP_OFS_ALLCALL = 8'h02;
    localparam logic [7:0] SLP_OFS_GROUP1 = 8'h03;
    localparam logic [7:0] SLP_OFS_GROUP2 = 8'h04;
    localparam logic [7:0] SLP_OFS_GROUP3 = 8'h05;
    localparam logic [7:0] SLP_OFS_STATUS = 8'h06;
    localparam logic [7:0] SLP_OFS_LAMP_BASE = 8'h20;
    localparam logic [2:0] SLP_LAMP_PAGE = 3'h1;

    localparam int unsigned SLP_MODE_EXTCLK_BIT = 0;
    localparam int unsigned SLP_MODE_ODRAIN_BIT = 1;
    localparam int unsigned SLP_MODE_GATELVL_BIT = 2;
    localparam int unsigned SLP_ADDR_EN_BIT = 7;

    localparam logic [2:0] SLP_MODE_RST = 3'h0;
    localparam logic [7:0] SLP_PRESCALE_RST = 8'h1e;
    localparam logic [7:0] SLP_PRESCALE_MIN = 8'h03;
    localparam logic [7:0] SLP_ALLCALL_RST = 8'hf0;
    localparam logic [7:0] SLP_GROUP1_RST = 8'h71;
    localparam logic [7:0] SLP_GROUP2_RST = 8'h72;
    localparam logic [7:0] SLP_GROUP3_RST = 8'h74;
    localparam logic [12:0] SLP_ON_RST = 13'h0000;
    localparam logic [12:0] SLP_OFF_RST = 13'h1000;

    localparam logic [6:0] SLP_GCALL_ADDR = 7'h00;
    localparam logic [7:0] SLP_BUS_SOFT_RESET_CALL_BYTE = 8'h06;
    localparam logic SLP_STRAP_MSB = 1'b1;

    typedef struct packed {
        logic gate_lvl;
        logic odrain;
        logic ext_clk;
    } slp_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } slp_reg_req_t;

    typedef struct packed {
        logic vld;
        logic first;
        logic [7:0] data;
    } slp_bus_byte_t;

endpackage

/* File: logic/slp_ram.sv */
// Small two-read-port table holding per-channel lamp settings.
`timescale 1ns/1ps
module slp_ram #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_a_addr_i,
    output logic [WIDTH-1:0] rd_a_data_o,
    input wire logic [AW-1:0] rd_b_addr_i,
    output logic [WIDTH-1:0] rd_b_data_o
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (wr_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        rd_a_data_o <= mem_ff[rd_a_addr_i];
        rd_b_data_o <= mem_ff[rd_b_addr_i];
    end
endmodule

/* File: logic/slp_addr_match.sv */
// Target address matcher and general-call soft reset detector.
`timescale 1ns/1ps
module slp_addr_match
    import slp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [5:0] strap_i,
    input wire logic [7:0] allcall_i,
    input wire logic [7:0] group1_i,
    input wire logic [7:0] group2_i,
    input wire logic [7:0] group3_i,
    input wire slp_pkg::slp_bus_byte_t byte_i,
    output logic hit_o,
    output logic soft_rst_o
);
    logic [5:0] strap_meta_ff;
    logic [5:0] strap_ff;
    logic gcall_ff;
    logic [6:0] addr7;

    function automatic logic alt_hit(input logic [7:0] cfg, input logic [6:0] a);
        alt_hit = cfg[SLP_ADDR_EN_BIT] && (cfg[6:0] == a);
    endfunction

    assign addr7 = byte_i.data[7:1];

    // Straps come from pins, so they pass two flops before matching.
    always_ff @(posedge clk_sys_i) begin
        strap_meta_ff <= strap_i;
        strap_ff <= strap_meta_ff;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hit_o <= 1'b0;
        end else if (byte_i.vld && byte_i.first) begin
            hit_o <= (addr7 == {SLP_STRAP_MSB, strap_ff})
                || alt_hit(allcall_i, addr7) || alt_hit(group1_i, addr7)
                || alt_hit(group2_i, addr7) || alt_hit(group3_i, addr7);
        end
    end

    // The soft reset needs the general-call address followed by its command byte.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            gcall_ff <= 1'b0;
            soft_rst_o <= 1'b0;
        end else begin
            soft_rst_o <= byte_i.vld && !byte_i.first && gcall_ff && (byte_i.data == SLP_BUS_SOFT_RESET_CALL_BYTE);
            if (byte_i.vld) begin
                gcall_ff <= byte_i.first && (byte_i.data == {SLP_GCALL_ADDR, 1'b0});
            end
        end
    end

    sequence s_gcall_addr;
        byte_i.vld && byte_i.first && byte_i.data == 8'h00;
    endsequence
    sequence s_bus_soft_reset_call_cmd;
        byte_i.vld && !byte_i.first && byte_i.data == 8'h06;
    endsequence

    // Helper: a general-call address byte arms the check until the next byte arrives.
    logic gc_armed_ff;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            gc_armed_ff <= 1'b0;
        end else if (byte_i.vld) begin
            gc_armed_ff <= byte_i.first && (byte_i.data == 8'h00);
        end
    end

    a_gcall_arm: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_gcall_addr |=> gcall_ff)
        else $error("general-call address did not arm the soft reset");
    // The soft reset raises our own reset one cycle later, so a disable clause would hide the result.
    a_soft_reset_call: assert property (@(posedge clk_sys_i)
        (!reset_i && gc_armed_ff) ##0 s_bus_soft_reset_call_cmd |=> soft_rst_o)
        else $error("soft reset call not recognised");
    a_strap_hit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        byte_i.vld && byte_i.first && addr7 == {1'b1, strap_ff} |=> hit_o)
        else $error("strapped address not matched");
endmodule

/* File: logic/slp_top.sv */
// Sixteen-channel lamp PWM engine with register port, prescaler and output stage.
`timescale 1ns/1ps
module slp_top
    import slp_pkg::*;
#(
    parameter int unsigned CH_NUM = 16,
    parameter int unsigned CNT_W = 12
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire slp_pkg::slp_reg_req_t req_i,
    output logic [15:0] rdata_o,
    input wire slp_pkg::slp_bus_byte_t bus_byte_i,
    input wire logic [5:0] strap_i,
    output logic addr_hit_o,
    input wire logic ext_clk_i,
    input wire logic gate_n_i,
    output logic [CH_NUM-1:0] lamp_output_n_o,
    output logic [CH_NUM-1:0] lamp_output_n_oe_o
);
    localparam int unsigned CH_AW = $clog2(CH_NUM);

    ////////////////////////////////////////////////////////////////////////////
    logic soft_rst;
    logic rst_all;
    slp_mode_t mode_ff;
    logic [7:0] prescale_ff;
    logic [7:0] allcall_ff;
    logic [7:0] group1_ff;
    logic [7:0] group2_ff;
    logic [7:0] group3_ff;
    logic [CH_NUM-1:0] on_vld_ff;
    logic [CH_NUM-1:0] off_vld_ff;
    logic lamp_sel;
    logic [CH_AW-1:0] lamp_ch;
    logic rd_lamp_ff;
    logic rd_is_off_ff;
    logic [CH_AW-1:0] rd_ch_ff;
    logic [15:0] rd_reg_ff;
    logic [SLP_SET_W-1:0] on_rd_a;
    logic [SLP_SET_W-1:0] off_rd_a;
    logic [SLP_SET_W-1:0] on_rd_b;
    logic [SLP_SET_W-1:0] off_rd_b;
    logic [SLP_SET_W-1:0] on_set;
    logic [SLP_SET_W-1:0] off_set;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic ext_rise;
    logic [1:0] osc_cnt_ff;
    logic osc_tick;
    logic src_tick;
    logic [7:0] pre_cnt_ff;
    logic cnt_step;
    logic [CNT_W-1:0] cnt_ff;
    logic [CH_AW-1:0] scan_ch_ff;
    logic [CH_AW-1:0] scan_ch_d_ff;
    logic scan_vld_ff;
    logic [CH_NUM-1:0] pwm_ff;
    logic [CH_NUM-1:0] lamp_level;

    // The general-call soft reset is folded into the system reset.
    assign rst_all = reset_i || soft_rst;

    function automatic logic in_window(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] on_c,
                                       input logic [CNT_W-1:0] off_c);
        if (on_c <= off_c) begin
            in_window = (cnt >= on_c) && (cnt < off_c);
        end else begin
            in_window = (cnt >= on_c) || (cnt < off_c);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    slp_addr_match u_match (
        .clk_sys_i(clk_sys_i),
        .reset_i(rst_all),
        .strap_i(strap_i),
        .allcall_i(allcall_ff),
        .group1_i(group1_ff),
        .group2_i(group2_ff),
        .group3_i(group3_ff),
        .byte_i(bus_byte_i),
        .hit_o(addr_hit_o),
        .soft_rst_o(soft_rst)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lamp settings live at base + 2*channel (on) and base + 2*channel + 1 (off).
    assign lamp_sel = (req_i.addr[7:5] == SLP_LAMP_PAGE);
    assign lamp_ch = req_i.addr[CH_AW:1];

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            mode_ff <= SLP_MODE_RST;
            prescale_ff <= SLP_PRESCALE_RST;
            allcall_ff <= SLP_ALLCALL_RST;
            group1_ff <= SLP_GROUP1_RST;
            group2_ff <= SLP_GROUP2_RST;
            group3_ff <= SLP_GROUP3_RST;
        end else if (req_i.wr) begin
            case (req_i.addr)
                SLP_OFS_MODE: begin
                    mode_ff <= {req_i.wdata[SLP_MODE_GATELVL_BIT], req_i.wdata[SLP_MODE_ODRAIN_BIT],
                                req_i.wdata[SLP_MODE_EXTCLK_BIT]};
                end
                SLP_OFS_PRESCALE: begin
                    // Values under the minimum would shorten the period below the rated top rate.
                    prescale_ff <= (req_i.wdata[7:0] < SLP_PRESCALE_MIN) ? SLP_PRESCALE_MIN
                                   : req_i.wdata[7:0];
                end
                SLP_OFS_ALLCALL: allcall_ff <= req_i.wdata[7:0];
                SLP_OFS_GROUP1: group1_ff <= req_i.wdata[7:0];
                SLP_OFS_GROUP2: group2_ff <= req_i.wdata[7:0];
                SLP_OFS_GROUP3: group3_ff <= req_i.wdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // The tables cannot be cleared in one cycle, so a valid bit stands in for reset values.
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            on_vld_ff <= '0;
            off_vld_ff <= '0;
        end else if (req_i.wr && lamp_sel) begin
            if (req_i.addr[0]) begin
                off_vld_ff[lamp_ch] <= 1'b1;
            end else begin
                on_vld_ff[lamp_ch] <= 1'b1;
            end
        end
    end

    slp_ram #(.WIDTH(SLP_SET_W), .DEPTH(CH_NUM)) u_on_ram (
        .clk_sys_i(clk_sys_i),
        .wr_i(req_i.wr && lamp_sel && !req_i.addr[0]),
        .wr_addr_i(lamp_ch),
        .wr_data_i(req_i.wdata[SLP_SET_W-1:0]),
        .rd_a_addr_i(lamp_ch),
        .rd_a_data_o(on_rd_a),
        .rd_b_addr_i(scan_ch_ff),
        .rd_b_data_o(on_rd_b)
    );

    slp_ram #(.WIDTH(SLP_SET_W), .DEPTH(CH_NUM)) u_off_ram (
        .clk_sys_i(clk_sys_i),
        .wr_i(req_i.wr && lamp_sel && req_i.addr[0]),
        .wr_addr_i(lamp_ch),
        .wr_data_i(req_i.wdata[SLP_SET_W-1:0]),
        .rd_a_addr_i(lamp_ch),
        .rd_a_data_o(off_rd_a),
        .rd_b_addr_i(scan_ch_ff),
        .rd_b_data_o(off_rd_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            rd_lamp_ff <= 1'b0;
            rd_is_off_ff <= 1'b0;
            rd_ch_ff <= '0;
            rd_reg_ff <= '0;
        end else begin
            rd_lamp_ff <= req_i.rd && lamp_sel;
            rd_is_off_ff <= req_i.addr[0];
            rd_ch_ff <= lamp_ch;
            rd_reg_ff <= '0;
            if (req_i.rd) begin
                case (req_i.addr)
                    SLP_OFS_MODE: rd_reg_ff <= {13'h0000, mode_ff};
                    SLP_OFS_PRESCALE: rd_reg_ff <= {8'h00, prescale_ff};
                    SLP_OFS_ALLCALL: rd_reg_ff <= {8'h00, allcall_ff};
                    SLP_OFS_GROUP1: rd_reg_ff <= {8'h00, group1_ff};
                    SLP_OFS_GROUP2: rd_reg_ff <= {8'h00, group2_ff};
                    SLP_OFS_GROUP3: rd_reg_ff <= {8'h00, group3_ff};
                    SLP_OFS_STATUS: rd_reg_ff <= {4'h0, cnt_ff};
                    default: rd_reg_ff <= '0;
                endcase
            end
        end
    end

    always_comb begin
        rdata_o = rd_reg_ff;
        if (rd_lamp_ff) begin
            if (rd_is_off_ff) begin
                rdata_o = {3'h0, off_vld_ff[rd_ch_ff] ? off_rd_a : SLP_OFF_RST};
            end else begin
                rdata_o = {3'h0, on_vld_ff[rd_ch_ff] ? on_rd_a : SLP_ON_RST};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The external clock is sampled, so it must stay well below half the system rate.
    always_ff @(posedge clk_sys_i) begin
        ext_meta_ff <= ext_clk_i;
        ext_sync_ff <= ext_meta_ff;
        ext_prev_ff <= ext_sync_ff;
    end
    assign ext_rise = ext_sync_ff && !ext_prev_ff;

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            osc_cnt_ff <= '0;
        end else if (osc_cnt_ff == 2'(SLP_OSC_DIV - 1)) begin
            osc_cnt_ff <= '0;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + 2'h1;
        end
    end
    assign osc_tick = (osc_cnt_ff == 2'(SLP_OSC_DIV - 1));

    assign src_tick = mode_ff.ext_clk ? ext_rise : osc_tick;
    assign cnt_step = src_tick && (pre_cnt_ff >= prescale_ff);

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            pre_cnt_ff <= '0;
        end else if (cnt_step) begin
            pre_cnt_ff <= '0;
        end else if (src_tick) begin
            pre_cnt_ff <= pre_cnt_ff + 8'h01;
        end
    end

    // One shared counter sets the period of every channel.
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            cnt_ff <= '0;
        end else if (cnt_step) begin
            cnt_ff <= cnt_ff + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels are evaluated round-robin; the window test is stateless, so a scan lag of
    // a few system cycles only delays an edge and never loses one.
    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            scan_ch_ff <= '0;
            scan_ch_d_ff <= '0;
            scan_vld_ff <= 1'b0;
        end else begin
            scan_ch_ff <= scan_ch_ff + 1'b1;
            scan_ch_d_ff <= scan_ch_ff;
            scan_vld_ff <= 1'b1;
        end
    end

    assign on_set = on_vld_ff[scan_ch_d_ff] ? on_rd_b : SLP_ON_RST;
    assign off_set = off_vld_ff[scan_ch_d_ff] ? off_rd_b : SLP_OFF_RST;

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            pwm_ff <= '0;
        end else if (scan_vld_ff) begin
            if (off_set[SLP_FULL_BIT]) begin
                pwm_ff[scan_ch_d_ff] <= 1'b0;
            end else if (on_set[SLP_FULL_BIT]) begin
                pwm_ff[scan_ch_d_ff] <= 1'b1;
            end else begin
                pwm_ff[scan_ch_d_ff] <= in_window(cnt_ff, on_set[CNT_W-1:0], off_set[CNT_W-1:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The gate pin bypasses the flops on purpose: it must act without a clock.
    assign lamp_level = gate_n_i ? pwm_ff : {CH_NUM{mode_ff.gate_lvl}};

    always_comb begin
        if (mode_ff.odrain) begin
            lamp_output_n_o = '0;
            lamp_output_n_oe_o = ~lamp_level;
        end else begin
            lamp_output_n_o = lamp_level;
            lamp_output_n_oe_o = '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper: cycles since the last counter step, saturating so that long gaps stay large.
    logic [4:0] step_gap_ff;

    always_ff @(posedge clk_sys_i) begin
        if (rst_all) begin
            step_gap_ff <= 5'h1f;
        end else if (cnt_step) begin
            step_gap_ff <= 5'h00;
        end else if (step_gap_ff != 5'h1f) begin
            step_gap_ff <= step_gap_ff + 5'h01;
        end
    end

    sequence s_scan_full_off;
        scan_vld_ff && off_set[12];
    endsequence

    a_reset_low: assert property (@(posedge clk_sys_i)
        rst_all |=> pwm_ff == 16'h0000)
        else $error("lamps not low after reset");
    a_gate_force: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        !gate_n_i |-> lamp_level == {16{mode_ff.gate_lvl}})
        else $error("gate did not force lamp level");
    a_full_off_wins: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        s_scan_full_off |=> !pwm_ff[$past(scan_ch_d_ff)])
        else $error("full off not obeyed");
    a_full_on_hold: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        scan_vld_ff && !off_set[12] && on_set[12] |=> pwm_ff[$past(scan_ch_d_ff)])
        else $error("full on not obeyed");
    a_count_step: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        !cnt_step |=> cnt_ff == $past(cnt_ff))
        else $error("counter moved without a step");
    a_step_spacing: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        cnt_step && !mode_ff.ext_clk |-> step_gap_ff >= 5'h0f)
        else $error("counter stepped faster than the minimum prescale");
    a_prescale_floor: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        prescale_ff >= 8'h03)
        else $error("prescale below minimum");
    a_odrain_low: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        mode_ff.odrain |-> lamp_output_n_o == 16'h0000 && lamp_output_n_oe_o == ~lamp_level)
        else $error("open-drain stage drove high");
    a_scan_visit: assert property (@(posedge clk_sys_i) disable iff (rst_all)
        scan_vld_ff && scan_ch_d_ff == 4'h0 |-> ##16 scan_ch_d_ff == 4'h0)
        else $error("channel scan did not cover sixteen channels");
endmodule

/* File: dv/slp_bus_ctrl_model.sv */
// Behavioural bus controller model: address and data bytes, external clock and output gate.
`timescale 1ns/1ps
module slp_bus_ctrl_model
    import slp_pkg::*;
(
    input wire logic clk_sys_i,
    output slp_pkg::slp_bus_byte_t bus_byte_o,
    output logic ext_clk_o,
    output logic gate_n_o
);
    import slp_pkg::*;

    initial begin
        bus_byte_o = '0;
        ext_clk_o = 1'b0;
        gate_n_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A released byte shows the inverse data so a stale byte never looks fresh.
    task automatic send_byte(input logic first, input logic [7:0] data);
        @(posedge clk_sys_i);
        bus_byte_o <= '{vld: 1'b1, first: first, data: data};
        @(posedge clk_sys_i);
        bus_byte_o <= '{vld: 1'b0, first: 1'b0, data: ~data};
    endtask

    task automatic soft_reset();
        send_byte(1'b1, {SLP_GCALL_ADDR, 1'b0});
        send_byte(1'b0, SLP_BUS_SOFT_RESET_CALL_BYTE);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // The clock stands low between bursts, as a synchronising master leaves it.
    task automatic run_ext(input int n);
        repeat (n) begin
            #80 ext_clk_o = 1'b1;
            #80 ext_clk_o = 1'b0;
        end
    endtask

    task automatic set_gate(input logic lvl);
        @(posedge clk_sys_i);
        gate_n_o <= lvl;
    endtask
endmodule

/* File: dv/slp_top_tb.sv */
// Self-checking testbench of the sixteen-channel lamp PWM block.
`timescale 1ns/1ps
module slp_top_tb;
    import slp_pkg::*;

    localparam logic [5:0] strap_val = 6'h15;
    localparam logic [7:0] def_addr [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h20, 8'h21};
    localparam logic [15:0] def_val [9] = '{16'h0000, 16'h001e, 16'h00f0, 16'h0071, 16'h0072, 16'h0074,
                                             16'h0000, 16'h0000, 16'h1000};
    localparam int duty_exp [5] = '{32768, 32768, 65536, 0, 65520};

    logic clk_sys_i;
    logic reset_i;
    slp_reg_req_t req;
    logic [15:0] rdata;
    slp_bus_byte_t bus_byte;
    logic addr_hit;
    logic ext_clk;
    logic gate_n;
    logic [15:0] lamp;
    logic [15:0] lamp_oe;
    logic [5:0] strap;
    int mismatches;
    int cmp_count;

    slp_top #(.CH_NUM(16), .CNT_W(12)) i_slp_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req),
        .rdata_o(rdata), .bus_byte_i(bus_byte), .strap_i(strap), .addr_hit_o(addr_hit), .ext_clk_i(ext_clk),
        .gate_n_i(gate_n), .lamp_output_n_o(lamp), .lamp_output_n_oe_o(lamp_oe));

    slp_bus_ctrl_model i_slp_bus_ctrl_model (.clk_sys_i(clk_sys_i), .bus_byte_o(bus_byte), .ext_clk_o(ext_clk),
        .gate_n_o(gate_n));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_sys_i);
        req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(posedge clk_sys_i);
        req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
        #1 d = rdata;
    endtask

    task automatic addr_byte(input logic [6:0] a, input logic exp);
        i_slp_bus_ctrl_model.send_byte(1'b1, {a, 1'b0});
        @(posedge clk_sys_i);
        #1 chk(addr_hit, exp, "address match");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        logic [15:0] d;
        chk(lamp, 16'h0000, "lamps low after reset");
        chk(lamp_oe, 16'hffff, "totem drive after reset");
        for (int i = 0; i < 9; i++) begin
            rd(def_addr[i], d);
            chk(d, def_val[i], "register default");
        end
    endtask

    task automatic t_regs();
        logic [15:0] d;
        wr(SLP_OFS_PRESCALE, 16'h0001);
        rd(SLP_OFS_PRESCALE, d);
        chk(d, 16'h0003, "prescale clamp");
        addr_byte({1'b1, strap_val}, 1'b1);
        addr_byte(7'h71, 1'b0);
        wr(SLP_OFS_GROUP1, 16'h00f1);
        addr_byte(7'h71, 1'b1);
        addr_byte(7'h01, 1'b0);
        addr_byte(7'h70, 1'b1);
        // Straps are pins: a new value needs the two synchroniser flops before it counts.
        @(posedge clk_sys_i);
        strap <= 6'h2a;
        repeat (3) @(posedge clk_sys_i);
        addr_byte(7'h6a, 1'b1);
        addr_byte({1'b1, strap_val}, 1'b0);
    endtask

    // One whole period at prescale 3 is 4096 steps of 16 cycles.
    task automatic t_pwm();
        logic [15:0] d;
        int cnt [5];
        wr(8'h21, 16'h0800);
        wr(8'h22, 16'h0c00);
        wr(8'h23, 16'h0400);
        wr(8'h24, 16'h1000);
        wr(8'h25, 16'h0000);
        wr(8'h29, 16'h0fff);
        rd(8'h21, d);
        chk(d, 16'h0800, "lamp word readback");
        cnt = '{0, 0, 0, 0, 0};
        repeat (100) @(posedge clk_sys_i);
        repeat (65536) begin
            @(posedge clk_sys_i);
            for (int i = 0; i < 5; i++) cnt[i] += (lamp[i] === 1'b1);
        end
        for (int i = 0; i < 5; i++) begin
            cmp_count++;
            if (cnt[i] > duty_exp[i] + 40 || cnt[i] < duty_exp[i] - 40) begin
                mismatches++;
                $display("MISMATCH %0t channel %0d high for %0d cycles", $time, i, cnt[i]);
            end
        end
    endtask

    task automatic t_gate();
        i_slp_bus_ctrl_model.set_gate(1'b0);
        #1 chk(lamp, 16'h0000, "gated low");
        wr(SLP_OFS_MODE, 16'h0004);
        @(posedge clk_sys_i);
        #1 chk(lamp, 16'hffff, "gated high");
        wr(SLP_OFS_MODE, 16'h0006);
        @(posedge clk_sys_i);
        #1 chk({lamp, lamp_oe}, 32'h0, "open drain gated high");
        i_slp_bus_ctrl_model.set_gate(1'b1);
        #1 chk(lamp_oe[3:2], 2'b10, "ungated open drain");
        wr(SLP_OFS_MODE, 16'h0000);
    endtask

    task automatic t_ext();
        logic [15:0] s0;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [11:0] dlt;
        wr(SLP_OFS_MODE, 16'h0001);
        rd(SLP_OFS_STATUS, s0);
        i_slp_bus_ctrl_model.run_ext(64);
        repeat (10) @(posedge clk_sys_i);
        rd(SLP_OFS_STATUS, s1);
        dlt = s1[11:0] - s0[11:0];
        cmp_count++;
        if (dlt < 12'd15 || dlt > 12'd17) begin
            mismatches++;
            $display("MISMATCH %0t external clock advanced %0d steps", $time, dlt);
        end
        repeat (100) @(posedge clk_sys_i);
        rd(SLP_OFS_STATUS, s2);
        chk(s2, s1, "counter still without external clock");
        wr(SLP_OFS_MODE, 16'h0000);
    endtask

    task automatic t_soft();
        wr(SLP_OFS_PRESCALE, 16'h0010);
        i_slp_bus_ctrl_model.soft_reset();
        repeat (3) @(posedge clk_sys_i);
        t_defaults();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // The longest scenario is one PWM period, so a million ns leaves ample slack.
    initial begin
        #1_000_000;
        mismatches++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        reset_i = 1'b1;
        req = '0;
        strap = strap_val;
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 t_defaults();
        t_regs();
        t_pwm();
        t_gate();
        t_ext();
        t_soft();
        results();
    end
endmodule
